//--- shared/srfs_consts.svh
// Constants for the serial register frame link: frame layout, offsets, timing.
// Included by the package and by both ends; definitions only.
`ifndef SRFS_CONSTS_SVH
`define SRFS_CONSTS_SVH
`define SRFS_FRAME_BITS    6'd32
`define SRFS_RID_DONE_CNT  6'd7
`define SRFS_CNT_SAT       6'd33
`define SRFS_CAUSE_W       8
`define SRFS_REG_FAULT     7'h00
`define SRFS_REG_SUPPLY    7'h01
`define SRFS_REG_PWRCTL    7'h02
`define SRFS_REG_SLEEP     7'h03
`define SRFS_REG_STATE     7'h04
`define SRFS_REG_REGFB     7'h05
`define SRFS_REG_DCFG0     7'h06
`define SRFS_REG_DCFG3     7'h09
`define SRFS_REG_DCMD      7'h12
`define SRFS_GSW_SFLT      10
`define SRFS_GSW_BWID      9
`define SRFS_GSW_ANYF      5
`define SRFS_CMD_TX        4'h0
`define SRFS_CMD_RX        4'h4
`define SRFS_CMD_STATUS    4'h8
`define SRFS_MCLK_NS       20
`define SRFS_SCK_PERIOD_NS 160
`define SRFS_SCK_HALF_CYC  (`SRFS_SCK_PERIOD_NS / 2 / `SRFS_MCLK_NS)
`endif

//--- shared/srfs_pkg.sv
// Types shared by both ends of the serial register frame link.
// Assumes srfs_consts.svh is on the include path.
`include "srfs_consts.svh"
package srfs_pkg;
   typedef enum logic [2:0] {
      OP_INIT   = 3'h0,
      OP_DIAG   = 3'h1,
      OP_SAFING = 3'h2,
      OP_SCRAP  = 3'h3,
      OP_ARMING = 3'h4
   } srfs_op_t;

   typedef enum logic [1:0] {WR_IGNORE = 2'h0, WR_OK = 2'h1, WR_DENIED = 2'h2} srfs_wr_t;
   typedef enum logic [1:0] {RD_UNUSED = 2'h0, RD_OK = 2'h1, RD_FORBID = 2'h2} srfs_rd_t;
   typedef enum logic {DS_IDLE = 1'b0, DS_FRAME = 1'b1} srfs_dst_t;
   typedef enum logic [1:0] {MS_IDLE = 2'h0, MS_LOW = 2'h1, MS_HIGH = 2'h3, MS_HOLD = 2'h2} srfs_mst_t;

   typedef struct packed {
      srfs_dst_t                     st;
      logic                          cs_m, cs_s, cs_p, sck_m, sck_s, sck_p, mosi_m, mosi_s;
      logic [5:0]                    cnt;
      logic [31:0]                   rx;
      logic [10:0]                   global_status_word;
      logic [19:0]                   rdata;
      logic                          rid_bad, rd_ok, miso, miso_oe, flt, bwid, sleep;
      logic [`SRFS_CAUSE_W-1:0]      fault;
      logic [15:0]                   supply, pwrctl, dcmd;
      logic [3:0][15:0]              dcfg;
   } srfs_dev_t;

   typedef struct packed {
      srfs_mst_t   st;
      logic        cs_n, sck, mosi, miso_m, miso_s, perr, done;
      logic [7:0]  tmr;
      logic [5:0]  bits;
      logic [31:0] tx, rx, rdata;
   } srfs_mreg_t;

   // Odd parity bit that makes the total count of ones odd
   function automatic logic odd_par(input logic [30:0] v);
      odd_par = ~(^v);
   endfunction : odd_par
endpackage : srfs_pkg

//--- shared/srfs_if.sv
// Serial link between host master and device slave.
// The shared data-out wire idles high when the slave releases it.
interface srfs_if;
   logic cs_n;
   logic sck;
   logic mosi;
   logic miso;
   logic miso_oe;
   logic miso_line;
   assign miso_line = miso_oe ? miso : 1'b1;
   modport master (output cs_n, output sck, output mosi, input miso_line);
   modport slave  (input cs_n, input sck, input mosi, output miso, output miso_oe);
endinterface : srfs_if

//--- hdl/srfs_slave.sv
// Device end: 32-bit frame slave with register map and access checks.
// Assumes mclk is well above the serial clock; link pins are synchronised here.
// How it works
// R1: A frame is exactly 32 clocks under select
// R2: Host sends read id, write id, parity, payload
// R3: Device returns status, parity, 20 data bits
// R4: Payload stored into write-id register
// R5: Returned data is read-id register content
// R6: Odd parity over each whole 32-bit frame
// R7: Idle select releases output, ignores input
// R8: Sample on rising edge, shift on falling
// R9: Most significant bit goes first
// R10: Wrong clock count discards, sets serial fault
// R11: Inbound parity error sets serial fault
// R12: Forbidden direction changes nothing, no fault
// R13: One bank bit serves both ids
// R14: State-forbidden write discarded, flagged next status
// R15: No write-id error for read-only targets
// R16: Unused read id flagged in current status
// R17: Supply configuration writable only in init
// R18: Power control writable in all states
// R19: Deploy configs writable except in init
// R20: Deploy command writable in safing, arming
// R21: State report shows machine and operating state
// R22: Reading fault status clears latched causes
// R23: Frame field positions fixed for both directions
// R24: Discarded frame also suppresses its read
//
// The strobed register port was decided locally.
`include "srfs_consts.svh"

module srfs_slave (
   input  wire logic                     mclk,
   input  wire logic                     rst_n,
   srfs_if.slave                         link,
   input  wire srfs_pkg::srfs_op_t       op_state,
   input  wire logic [3:0]               pwr_state,
   input  wire logic [15:0]              regulator_fb,
   input  wire logic [`SRFS_CAUSE_W-1:0] reset_cause,
   output logic [15:0]                   supply_cfg,
   output logic [15:0]                   pwr_ctl,
   output logic [63:0]                   deploy_cfg,
   output logic [15:0]                   deploy_cmd,
   output logic                          sleep_pulse
);
   srfs_pkg::srfs_dev_t r_reg, r_next;

   function automatic srfs_pkg::srfs_wr_t wr_class(input logic bank, input logic [6:0] id,
                                                   input srfs_pkg::srfs_op_t op);
      logic ok;
      ok = 1'b0;
      wr_class = srfs_pkg::WR_OK;
      if (bank) begin                                              // R13
         wr_class = srfs_pkg::WR_IGNORE;
      end else begin
         case (id)
            `SRFS_REG_SUPPLY: ok = (op == srfs_pkg::OP_INIT);      // R17
            `SRFS_REG_PWRCTL,
            `SRFS_REG_SLEEP:  ok = 1'b1;                           // R18
            `SRFS_REG_DCMD:   ok = (op == srfs_pkg::OP_SAFING) || (op == srfs_pkg::OP_ARMING); // R20
            default: begin
               if (id >= `SRFS_REG_DCFG0 && id <= `SRFS_REG_DCFG3) begin
                  ok = (op != srfs_pkg::OP_INIT);                  // R19
               end else begin
                  wr_class = srfs_pkg::WR_IGNORE;                  // R12 R15
               end
            end
         endcase
         if (wr_class == srfs_pkg::WR_OK && !ok) begin
            wr_class = srfs_pkg::WR_DENIED;                        // R14
         end
      end
   endfunction : wr_class

   function automatic srfs_pkg::srfs_rd_t rd_class(input logic bank, input logic [6:0] id);
      rd_class = srfs_pkg::RD_UNUSED;
      if (!bank) begin                                             // R13
         if (id == `SRFS_REG_SLEEP) begin
            rd_class = srfs_pkg::RD_FORBID;                        // R12
         end else if (id <= `SRFS_REG_DCFG3 || id == `SRFS_REG_DCMD) begin
            rd_class = srfs_pkg::RD_OK;
         end
      end
   endfunction : rd_class

   logic                 cs_fall, cs_rise, sck_rise, sck_fall, valid, clr_fault;
   logic [7:0]           head;
   logic [31:0]          frame_out;
   srfs_pkg::srfs_rd_t   rc;
   srfs_pkg::srfs_wr_t   wc;
   logic [6:0]           write_reg_id;
   logic [15:0]          pay;

   always_comb begin
      r_next = r_reg;
      clr_fault = 1'b0;
      head = {r_reg.rx[6:0], r_reg.mosi_s};
      rc = rd_class(head[7], head[6:0]);
      write_reg_id = r_reg.rx[23:17];                                       // R23
      pay = r_reg.rx[15:0];
      wc = wr_class(r_reg.rx[31], write_reg_id, op_state);
      frame_out = {r_reg.global_status_word[10:1], r_reg.rid_bad,
                   srfs_pkg::odd_par({r_reg.global_status_word[10:1], r_reg.rid_bad, r_reg.rdata}), r_reg.rdata}; // R3 R6 R23
      // Two-stage synchronisers, third stage only for edge finding
      r_next.cs_m = link.cs_n;
      r_next.cs_s = r_reg.cs_m;
      r_next.cs_p = r_reg.cs_s;
      r_next.sck_m = link.sck;
      r_next.sck_s = r_reg.sck_m;
      r_next.sck_p = r_reg.sck_s;
      r_next.mosi_m = link.mosi;
      r_next.mosi_s = r_reg.mosi_m;
      cs_fall = !r_reg.cs_s && r_reg.cs_p;
      cs_rise = r_reg.cs_s && !r_reg.cs_p && (r_reg.st == srfs_pkg::DS_FRAME);
      sck_rise = (r_reg.st == srfs_pkg::DS_FRAME) && !r_reg.cs_s && r_reg.sck_s && !r_reg.sck_p; // R7 R8
      sck_fall = (r_reg.st == srfs_pkg::DS_FRAME) && !r_reg.cs_s && !r_reg.sck_s && r_reg.sck_p; // R8
      valid = (r_reg.cnt == `SRFS_FRAME_BITS) && (^r_reg.rx);     // R1 R6
      r_next.sleep = 1'b0;
      case (r_reg.st)
         srfs_pkg::DS_IDLE: begin
            r_next.miso_oe = 1'b0;                                 // R7
            if (cs_fall) begin
               r_next.st = srfs_pkg::DS_FRAME;
               r_next.cnt = '0;
               r_next.global_status_word = '0;
               r_next.global_status_word[`SRFS_GSW_SFLT] = r_reg.flt;
               r_next.global_status_word[`SRFS_GSW_BWID] = r_reg.bwid;            // R14
               r_next.global_status_word[8:6] = op_state;
               r_next.global_status_word[`SRFS_GSW_ANYF] = |r_reg.fault;
               r_next.flt = 1'b0;
               r_next.bwid = 1'b0;
               r_next.rdata = '0;
               r_next.rid_bad = 1'b0;
               r_next.rd_ok = 1'b0;
               r_next.miso = r_reg.flt;                            // R9
               r_next.miso_oe = 1'b1;
            end
         end
         srfs_pkg::DS_FRAME: begin
            if (sck_rise) begin
               r_next.rx = {r_reg.rx[30:0], r_reg.mosi_s};         // R8 R9
               if (r_reg.cnt != `SRFS_CNT_SAT) begin
                  r_next.cnt = r_reg.cnt + 6'd1;                   // R10
               end
               if (r_reg.cnt == `SRFS_RID_DONE_CNT) begin
                  r_next.rid_bad = (rc == srfs_pkg::RD_UNUSED);    // R16
                  r_next.rd_ok = (rc == srfs_pkg::RD_OK);
                  // Bank one or unused id: data stays zero, only the flag tells; write-only id: data zero, no flag
                  if (rc == srfs_pkg::RD_OK) begin                 // R13 R16
                     case (head[6:0])                              // R5
                        `SRFS_REG_FAULT:  r_next.rdata = 20'(r_reg.fault);
                        `SRFS_REG_SUPPLY: r_next.rdata = {4'h0, r_reg.supply};
                        `SRFS_REG_PWRCTL: r_next.rdata = {4'h0, r_reg.pwrctl};
                        `SRFS_REG_STATE:  r_next.rdata = {13'h0, pwr_state, op_state}; // R21
                        `SRFS_REG_REGFB:  r_next.rdata = {4'h0, regulator_fb};
                        `SRFS_REG_DCMD:   r_next.rdata = {4'h0, r_reg.dcmd};
                        default: begin
                           r_next.rdata = {4'h0, r_reg.dcfg[2'(head[6:0] - `SRFS_REG_DCFG0)]};
                        end
                     endcase
                  end
               end
            end
            if (sck_fall && r_reg.cnt < `SRFS_FRAME_BITS) begin
               r_next.miso = frame_out[5'(6'd31 - r_reg.cnt)];     // R8 R9
            end
            if (cs_rise) begin
               r_next.st = srfs_pkg::DS_IDLE;
               r_next.miso_oe = 1'b0;                              // R7
               if (!valid) begin
                  r_next.flt = 1'b1;                               // R10 R11 R24
               end else begin
                  clr_fault = r_reg.rd_ok && (r_reg.rx[30:24] == `SRFS_REG_FAULT); // R22
                  if (wc == srfs_pkg::WR_DENIED) begin
                     r_next.bwid = 1'b1;                           // R14
                  end else if (wc == srfs_pkg::WR_OK) begin
                     case (write_reg_id)                                    // R4
                        `SRFS_REG_SUPPLY: r_next.supply = pay;
                        `SRFS_REG_PWRCTL: r_next.pwrctl = pay;
                        `SRFS_REG_SLEEP:  r_next.sleep = 1'b1;
                        `SRFS_REG_DCMD:   r_next.dcmd = pay;
                        default:          r_next.dcfg[2'(write_reg_id - `SRFS_REG_DCFG0)] = pay;
                     endcase
                  end
               end
            end
         end
         default: r_next.st = srfs_pkg::DS_IDLE;
      endcase
      // A cause arriving in the clearing cycle survives the read
      r_next.fault = (clr_fault ? '0 : r_reg.fault) | reset_cause; // R22
   end

   // Synchronous reset clears the whole state struct, latched causes included
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign link.miso    = r_reg.miso;
   assign link.miso_oe = r_reg.miso_oe;
   assign supply_cfg   = r_reg.supply;
   assign pwr_ctl      = r_reg.pwrctl;
   assign deploy_cfg   = r_reg.dcfg;
   assign deploy_cmd   = r_reg.dcmd;
   assign sleep_pulse  = r_reg.sleep;
endmodule : srfs_slave

//--- hdl/srfs_master.sv
// Host end: makes the serial clock, sends one 32-bit frame per command.
// Assumes a simple register port from software; data-out line idles high.
`include "srfs_consts.svh"
module srfs_master #(
   parameter int SCK_HALF = `SRFS_SCK_HALF_CYC
) (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   srfs_if.master           link,
   input  wire logic [3:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [31:0]      rdata
);
   localparam logic [7:0] HALF_M1 = 8'(SCK_HALF - 1);
   srfs_pkg::srfs_mreg_t r_reg, r_next;

   always_comb begin
      r_next = r_reg;
      r_next.miso_m = link.miso_line;
      r_next.miso_s = r_reg.miso_m;
      r_next.rdata = '0;
      if (rd) begin
         case (addr)
            `SRFS_CMD_RX:     r_next.rdata = r_reg.rx;
            `SRFS_CMD_STATUS: r_next.rdata = {29'h0, r_reg.perr, r_reg.done, r_reg.st != srfs_pkg::MS_IDLE};
            default:          r_next.rdata = '0;
         endcase
         if (addr == `SRFS_CMD_STATUS) begin
            r_next.done = 1'b0;
         end
      end
      case (r_reg.st)
         srfs_pkg::MS_IDLE: begin
            r_next.cs_n = 1'b1;
            r_next.sck = 1'b0;
            if (wr && addr == `SRFS_CMD_TX) begin
               r_next.tx = {wdata[31:17], srfs_pkg::odd_par({wdata[31:17], wdata[15:0]}), wdata[15:0]}; // R2 R6 R23
               r_next.mosi = wdata[31];                            // R9
               r_next.cs_n = 1'b0;
               r_next.tmr = '0;
               r_next.bits = '0;
               r_next.st = srfs_pkg::MS_LOW;
            end
         end
         srfs_pkg::MS_LOW: begin
            r_next.tmr = r_reg.tmr + 8'd1;
            if (r_reg.tmr == HALF_M1) begin
               r_next.tmr = '0;
               r_next.sck = 1'b1;
               r_next.st = srfs_pkg::MS_HIGH;
            end
         end
         srfs_pkg::MS_HIGH: begin
            r_next.tmr = r_reg.tmr + 8'd1;
            if (r_reg.tmr == HALF_M1) begin
               // Sampled late in the high phase to cover sync delay on both sides
               r_next.tmr = '0;
               r_next.sck = 1'b0;                                  // R8
               r_next.rx = {r_reg.rx[30:0], r_reg.miso_s};         // R9
               r_next.bits = r_reg.bits + 6'd1;
               r_next.tx = {r_reg.tx[30:0], 1'b0};
               r_next.mosi = r_reg.tx[30];                         // R8
               r_next.st = (r_reg.bits == `SRFS_FRAME_BITS - 6'd1) ? srfs_pkg::MS_HOLD : srfs_pkg::MS_LOW; // R1
            end
         end
         srfs_pkg::MS_HOLD: begin
            r_next.tmr = r_reg.tmr + 8'd1;
            if (r_reg.tmr == HALF_M1) begin
               r_next.cs_n = 1'b1;
               r_next.perr = !(^r_reg.rx);                         // R6
               r_next.done = 1'b1;
               r_next.st = srfs_pkg::MS_IDLE;
            end
         end
         default: r_next.st = srfs_pkg::MS_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         r_reg <= '0;
         r_reg.cs_n <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign link.cs_n = r_reg.cs_n;
   assign link.sck  = r_reg.sck;
   assign link.mosi = r_reg.mosi;
   assign rdata     = r_reg.rdata;
endmodule : srfs_master

//--- verification/srfs_link_properties.sv
// Wire-level checks for the serial register frame link between the two ends.
// Assumes the master's sck and cs_n are registers on mclk, as is the slave's miso.
module srfs_link_checker (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe,
   input wire logic miso_line
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        sck_d_reg;
   logic [5:0]  nclk_reg;
   logic [5:0]  idle_reg;
   logic [31:0] in_sh_reg;
   logic [31:0] out_sh_reg;
   // Capture on the master's own sck register: no synchroniser delay to model
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sck_d_reg  <= 1'b0;
         nclk_reg   <= 6'h00;
         idle_reg   <= 6'h00;
         in_sh_reg  <= 32'h0;
         out_sh_reg <= 32'h0;
      end else begin
         sck_d_reg <= sck;
         idle_reg  <= !cs_n ? 6'h00 : (idle_reg == 6'h3f) ? idle_reg : idle_reg + 6'h01;
         if (cs_n) begin
            nclk_reg <= 6'h00;
         end else if (sck && !sck_d_reg) begin
            nclk_reg   <= nclk_reg + 6'h01;
            in_sh_reg  <= {in_sh_reg[30:0], mosi};
            out_sh_reg <= {out_sh_reg[30:0], miso_line};
         end
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   chk_frame_length: assert property ($rose(cs_n) |-> nclk_reg == 6'd32)
      else $error("frame not 32 clocks");
   chk_sck_still: assert property (cs_n |-> !sck)
      else $error("serial clock runs outside frame");
   chk_idle_release: assert property (idle_reg >= 6'd6 |-> !miso_oe)
      else $error("data out driven while deselected");
   chk_drive_select: assert property ($fell(cs_n) |-> ##[1:6] miso_oe)
      else $error("data out not driven in frame");
   chk_mosi_hold: assert property ((sck && $past(sck)) |-> $stable(mosi))
      else $error("host data moved while clock high");
   chk_miso_hold: assert property ((miso_oe && sck && $past(sck)) |-> $stable(miso))
      else $error("device data moved while clock high");
   chk_in_parity: assert property (($rose(cs_n) && nclk_reg == 6'd32) |-> ^in_sh_reg)
      else $error("inbound frame parity even");
   chk_out_parity: assert property (($rose(cs_n) && nclk_reg == 6'd32) |-> ^out_sh_reg)
      else $error("returned frame parity even");
   chk_gsw_spare: assert property (($rose(cs_n) && nclk_reg == 6'd32) |-> out_sh_reg[25:22] == 4'h0)
      else $error("spare status bits set");
   cover property ($rose(cs_n) && nclk_reg == 6'd32);
   cover property ($rose(cs_n) && out_sh_reg[21]);
   cover property ($rose(cs_n) && out_sh_reg[30]);
endmodule : srfs_link_checker

//--- verification/tb_spi_register_frame_slave.sv
// Bench: master and slave on one link, a second slave on bench-driven broken frames.
// Assumes srfs_consts.svh, srfs_pkg and srfs_if are compiled first.
`include "srfs_consts.svh"
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin fails++; $display("BAD %s exp %h got %h", nm, e, s); end end
module tb_spi_register_frame_slave;
   timeunit 1ns;
   timeprecision 1ps;
   logic                mclk, rst_n, wr, rd, sleep_pulse;
   logic [3:0]          addr, pwr_state;
   logic [31:0]         wdata, rdata;
   srfs_pkg::srfs_op_t  op_state;
   logic [15:0]         regulator_fb, supply_cfg, pwr_ctl, deploy_cmd, pwr_ctl_b;
   logic [63:0]         deploy_cfg;
   logic [7:0]          reset_cause;
   logic [15:0]         mdl [7];
   logic [6:0]          ids [8] = '{7'h01, 7'h02, 7'h06, 7'h07, 7'h08, 7'h09, 7'h12, 7'h04};
   logic                bw;
   int                  fails, n_compared, cyc, n_sleep;
   srfs_if link ();
   srfs_if link_b ();
   srfs_master #(.SCK_HALF(4)) i_srfs_master (.mclk(mclk), .rst_n(rst_n), .link(link.master), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   srfs_slave i_srfs_slave (.mclk(mclk), .rst_n(rst_n), .link(link.slave), .op_state(op_state),
      .pwr_state(pwr_state), .regulator_fb(regulator_fb), .reset_cause(reset_cause), .supply_cfg(supply_cfg),
      .pwr_ctl(pwr_ctl), .deploy_cfg(deploy_cfg), .deploy_cmd(deploy_cmd), .sleep_pulse(sleep_pulse));
   srfs_slave i_srfs_slave_b (.mclk(mclk), .rst_n(rst_n), .link(link_b.slave), .op_state(op_state),
      .pwr_state(pwr_state), .regulator_fb(regulator_fb), .reset_cause(reset_cause), .supply_cfg(),
      .pwr_ctl(pwr_ctl_b), .deploy_cfg(), .deploy_cmd(), .sleep_pulse());
   srfs_link_checker i_srfs_link_checker (.mclk(mclk), .rst_n(rst_n), .cs_n(link.cs_n), .sck(link.sck),
      .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe), .miso_line(link.miso_line));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // Cut a hang short: the whole run needs about 13000 cycles
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fails++;
         end_sim();
      end
   end
   // Sleep is a one-cycle pulse, so counting high cycles also catches a stretched one
   always @(posedge mclk) begin
      if (sleep_pulse === 1'b1) begin
         n_sleep <= n_sleep + 1;
      end
   end
   function automatic logic [31:0] mk(input logic b, input logic [6:0] r, w, input logic [15:0] p);
      return {b, r, w, ~^{b, r, w, p}, p};
   endfunction : mk
   function automatic logic [10:0] global_status_word(input logic sf, bwf, input logic [2:0] op, input logic af, br);
      return {sf, bwf, op, af, 4'h0, br};
   endfunction : global_status_word
   function automatic logic allow(input logic [6:0] id, input logic [2:0] op);
      case (id)
         7'h01: return op == 3'h0;
         7'h02: return 1'b1;
         7'h12: return op == 3'h2 || op == 3'h4;
         default: return op != 3'h0;
      endcase
   endfunction : allow
   task automatic cmd_wr(input logic [3:0] a, input logic [31:0] d);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      @(posedge mclk);
   endtask : cmd_wr
   task automatic cmd_rd(input logic [3:0] a, output logic [31:0] v);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 v = rdata;
      @(posedge mclk);
   endtask : cmd_rd
   task automatic xfer(input logic [31:0] f, input logic [10:0] g, input logic [19:0] d, input string nm);
      logic [31:0] st, got;
      int          n;
      cmd_wr(4'h0, f);
      st = 32'h0;
      n = 0;
      while (st[1] !== 1'b1 && n < 400) begin
         cmd_rd(4'h8, st);
         n++;
      end
      `CHK("frame done", 1'b1, st[1])
      `CHK("rx parity flag", 1'b0, st[2])
      cmd_rd(4'h4, got);
      `CHK(nm, {g, ~^{g, d}, d}, got)
      repeat (4) @(posedge mclk);
   endtask : xfer
   // Bench plays host on the second link; data line toggles once released
   task automatic bang(input int n, input logic [31:0] f, output logic [31:0] got);
      got = 32'h0;
      link_b.cs_n <= 1'b0;
      for (int i = 0; i < n; i++) begin
         link_b.mosi <= f[31 - (i % 32)];
         repeat (4) @(posedge mclk);
         link_b.sck <= 1'b1;
         got = {got[30:0], link_b.miso_line};
         repeat (4) @(posedge mclk);
         link_b.sck <= 1'b0;
      end
      repeat (4) @(posedge mclk);
      link_b.cs_n <= 1'b1;
      link_b.mosi <= ~link_b.mosi;
      repeat (8) @(posedge mclk);
   endtask : bang
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      logic [31:0] got;
      logic [15:0] p;
      int          ri, wi;
      rst_n = 1'b0;
      {wr, rd, addr, wdata, pwr_state, regulator_fb, reset_cause} = '0;
      op_state = srfs_pkg::OP_INIT;
      link_b.cs_n = 1'b1;
      link_b.sck = 1'b0;
      link_b.mosi = 1'b0;
      {fails, n_compared, cyc, bw} = '0;
      for (int i = 0; i < 7; i++) mdl[i] = 16'h0;
      void'($urandom(89667));
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      `CHK("reset regs", 112'h0, {supply_cfg, pwr_ctl, deploy_cfg, deploy_cmd})
      $display("test reset done");
      for (int s = 0; s < 5; s++) begin
         op_state <= srfs_pkg::srfs_op_t'(s);
         for (int k = 0; k < 8; k++) begin
            ri = $urandom_range(7);
            wi = (k < 7) ? k : $urandom_range(6);
            p = 16'($urandom());
            pwr_state <= 4'($urandom());
            regulator_fb <= 16'($urandom());
            @(posedge mclk);
            xfer(mk(1'b0, ids[ri], ids[wi], p), global_status_word(1'b0, bw, 3'(s), 1'b0, 1'b0),
               (ri == 7) ? {13'h0, pwr_state, 3'(s)} : {4'h0, mdl[ri]}, "state frame");
            bw = !allow(ids[wi], 3'(s));
            if (!bw) mdl[wi] = p;
            `CHK("regs", {mdl[0], mdl[1], mdl[5], mdl[4], mdl[3], mdl[2], mdl[6]}, {supply_cfg, pwr_ctl, deploy_cfg, deploy_cmd})
         end
      end
      $display("test state permissions done");
      reset_cause <= 8'h05;
      @(posedge mclk);
      reset_cause <= 8'h00;
      @(posedge mclk);
      xfer(mk(1'b0, 7'h0a, 7'h05, 16'hbeef), global_status_word(1'b0, bw, 3'h4, 1'b1, 1'b1), 20'h0, "unused rid");
      xfer(mk(1'b1, 7'h00, 7'h02, 16'h1234), global_status_word(1'b0, 1'b0, 3'h4, 1'b1, 1'b1), 20'h0, "bank one");
      xfer(mk(1'b0, 7'h00, 7'h04, 16'h4321), global_status_word(1'b0, 1'b0, 3'h4, 1'b1, 1'b0), 20'h5, "fault read");
      xfer(mk(1'b0, 7'h05, 7'h03, 16'h0), global_status_word(1'b0, 1'b0, 3'h4, 1'b0, 1'b0),
         {4'h0, regulator_fb}, "fault cleared");
      `CHK("regs kept", {mdl[1], mdl[6]}, {pwr_ctl, deploy_cmd})
      `CHK("sleep pulse", 1, n_sleep)
      $display("test refused accesses done");
      bang(31, mk(1'b0, 7'h04, 7'h02, 16'h5a5a), got);
      bang(33, mk(1'b0, 7'h04, 7'h02, 16'h5a5a), got);
      bang(32, mk(1'b0, 7'h00, 7'h02, 16'h5a5a) ^ 32'h1, got);
      `CHK("length fault flag", 1'b1, got[31])
      bang(32, mk(1'b0, 7'h04, 7'h0a, 16'h0), got);
      `CHK("parity fault flag", 1'b1, got[31])
      `CHK("fault kept", 1'b1, got[26])
      `CHK("no broken write", 16'h0, pwr_ctl_b)
      $display("test broken frames done");
      end_sim();
   end
endmodule : tb_spi_register_frame_slave
